/* File: include/spimsp_pkg.sv */
// Purpose: shared constants and a divider function for the serial port device and its partner end
// Assumes: 8-bit control/status/data registers, one cpu clock domain
// Notes:   control and status bit positions, divider codes, apb word offsets
package spimsp_pkg;
    // control register field positions
    localparam int CTL_IE   = 7;                 // port_interrupt_enable
    localparam int CTL_OE   = 6;                 // port_output_enable
    localparam int CTL_DIV  = 5;                 // divider_enable_bit
    localparam int CTL_MS   = 4;                 // master_select
    localparam int CTL_POL  = 3;                 // clock_idle_level
    localparam int CTL_PHA  = 2;                 // capture_edge_select
    // status register field positions
    localparam int STS_TC   = 7;                 // transfer_complete_flag
    localparam int STS_WC   = 6;                 // write collision
    localparam int STS_OV   = 5;                 // overrun_flag
    localparam int STS_MF   = 4;                 // mode_fault_flag
    localparam int STS_OD   = 2;                 // output disable
    localparam int STS_SM   = 1;                 // software select management
    localparam int STS_SS   = 0;                 // soft_select_level
    // reset values
    localparam logic [7:0] CTL_RST = 8'h00;      // upper nibble zero, low nibble defined as zero
    localparam logic [7:0] STS_RST = 8'h00;
    localparam logic [3:0] STS_WMASK = 4'h7;     // software-writable status bits 2:0
    // apb word offsets of the device register window
    localparam logic [7:0] OFS_DATA = 8'h00;
    localparam logic [7:0] OFS_CTL  = 8'h04;
    localparam logic [7:0] OFS_STS  = 8'h08;
    localparam logic [7:0] OFS_PWR  = 8'h0C;     // bit0 wait, bit1 halt, bit2 cpu mask
    localparam logic [7:0] OFS_WAKE = 8'h10;     // bit0 irq, bit1 wake request
    // half-period of sck in cpu cycles for each divider code {div, rate[1:0]}
    function automatic logic [6:0] half_div(input logic [2:0] code);
        unique case (code)
            3'b100:  half_div = 7'h02;           // /4
            3'b000:  half_div = 7'h04;           // /8
            3'b001:  half_div = 7'h08;           // /16
            3'b110:  half_div = 7'h10;           // /32
            3'b010:  half_div = 7'h20;           // /64
            3'b011:  half_div = 7'h40;           // /128
            default: half_div = 7'h40;           // unused codes run slowest
        endcase
    endfunction
endpackage

/* File: include/spimsp_if.sv */
// Purpose: serial link between the documented port and its partner end
// Assumes: both ends run on the same pclk; pins resolved from enables here
// Notes:   no clocking block
`timescale 1ns/1ps
interface spimsp_if;
    logic sck_o_d, sck_oe_d, mosi_o_d, mosi_oe_d, miso_o_d, miso_oe_d; // device drives
    logic sck_o_p, sck_oe_p, mosi_o_p, mosi_oe_p, miso_o_p, miso_oe_p; // partner drives
    logic ss_n;                                  // select driven by partner
    logic sck, mosi, miso;                       // resolved wires, pulled low when idle
    assign sck  = sck_oe_d  ? sck_o_d  : (sck_oe_p  ? sck_o_p  : 1'b0);
    assign mosi = mosi_oe_d ? mosi_o_d : (mosi_oe_p ? mosi_o_p : 1'b0);
    assign miso = miso_oe_d ? miso_o_d : (miso_oe_p ? miso_o_p : 1'b0);
    modport dev  (input sck, mosi, miso, ss_n,
                  output sck_o_d, sck_oe_d, mosi_o_d, mosi_oe_d, miso_o_d, miso_oe_d);
    modport peer (input sck, mosi, miso,
                  output sck_o_p, sck_oe_p, mosi_o_p, mosi_oe_p, miso_o_p, miso_oe_p, ss_n);
endinterface

/* File: design/spimsp_port.sv */
// Purpose: documented serial port, master or slave, with apb register window
// Assumes: pclk 125 MHz; link pins from outside pass two flip-flops
// Notes:   halt and wait come from a power controller via a register
`timescale 1ns/1ps
module spimsp_port
    import spimsp_pkg::*;
(
    // apb slave
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // link
    spimsp_if.dev            lnk,
    // cpu side
    output logic             irq,
    output logic             wake_halt
);
    import spimsp_pkg::*;

    typedef struct packed {
        logic [7:0] ctl;        // control register
        logic [7:0] sts;        // status register
        logic [7:0] shf;        // shift register
        logic [7:0] buf_rx;     // receive buffer read by software
        logic [3:0] bitc;       // bits left in byte
        logic [6:0] div;        // master half-period counter
        logic       busy;       // master transfer in progress
        logic       sck;        // master sck level
        logic       edge2;      // next edge is second of pair
        logic       tc_armed;   // status seen while done flag set
        logic       mf_armed;   // status read while fault set
        logic [2:0] pwr;        // wait, halt, cpu mask
        logic       sel_at_halt;// select low when halt began
        logic [2:0] sck_s, mosi_s, miso_s, ss_s; // sync chains, bit2 = prev
        logic       rxbit;      // sampled bit waiting for shift edge
        logic [31:0] rd;        // read data register
    } spimsp_s;

    spimsp_s st_ff, nxt_st;

    ////////////////////////////////////////////////////////////////////////
    // combinational view
    logic acc, wr_acc, rd_setup;
    logic ss_in, sck_in, sck_prev, din, halted;
    assign acc    = psel & penable;
    assign wr_acc = acc & pwrite;
    // read word loads in the setup cycle so it already stands at the access edge
    assign rd_setup = psel & ~penable & ~pwrite;
    assign pready  = 1'b1;                                   // zero wait states
    assign pslverr = 1'b0;
    assign prdata  = st_ff.rd;
    assign halted  = st_ff.pwr[1];
    // select from pin or soft bit
    assign ss_in  = st_ff.sts[STS_SM] ? st_ff.sts[STS_SS] : st_ff.ss_s[1];
    assign sck_in   = st_ff.sck_s[1];
    assign sck_prev = st_ff.sck_s[2];
    assign din    = st_ff.ctl[CTL_MS] ? st_ff.miso_s[1] : st_ff.mosi_s[1];
    // interrupt: done, fault or overrun flag, enable bit, cpu unmasked
    assign irq = st_ff.ctl[CTL_IE] & ~st_ff.pwr[2] &
                 (st_ff.sts[STS_TC] | st_ff.sts[STS_MF] | st_ff.sts[STS_OV]);
    // halt exit only from done flag as slave with select low at entry
    assign wake_halt = halted & st_ff.sel_at_halt & st_ff.ctl[CTL_IE] &
                       st_ff.sts[STS_TC] & ~st_ff.ctl[CTL_MS];

    // pin drive
    assign lnk.sck_o_d   = st_ff.sck;
    assign lnk.sck_oe_d  = st_ff.ctl[CTL_OE] & st_ff.ctl[CTL_MS];
    assign lnk.mosi_o_d  = st_ff.shf[7];
    assign lnk.mosi_oe_d = st_ff.ctl[CTL_OE] & st_ff.ctl[CTL_MS] & ~st_ff.sts[STS_OD];
    assign lnk.miso_o_d  = st_ff.shf[7];
    assign lnk.miso_oe_d = st_ff.ctl[CTL_OE] & ~st_ff.ctl[CTL_MS] & ~ss_in &
                           ~st_ff.sts[STS_OD];

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic cap, sft, done, slv_edge, master_select_edge;
        logic [7:0] shf_n;
        nxt_st    = st_ff;
        cap       = 1'b0;
        sft       = 1'b0;
        done      = 1'b0;
        slv_edge  = 1'b0;
        master_select_edge = 1'b0;
        shf_n     = st_ff.shf;
        // synchronisers always run so pins are fresh after halt
        nxt_st.sck_s  = {st_ff.sck_s[1:0],  lnk.sck};
        nxt_st.mosi_s = {st_ff.mosi_s[1:0], lnk.mosi};
        nxt_st.miso_s = {st_ff.miso_s[1:0], lnk.miso};
        nxt_st.ss_s   = {st_ff.ss_s[1:0],   lnk.ss_n};
        // power controller register stays writable while halted
        if (wr_acc && paddr == OFS_PWR) begin
            nxt_st.pwr = pwdata[2:0];
            if (pwdata[1] && !st_ff.pwr[1]) begin
                nxt_st.sel_at_halt = ~ss_in;
            end
        end
        if (wake_halt) begin
            nxt_st.pwr[1] = 1'b0;
        end
        if (!halted || (!st_ff.ctl[CTL_MS] && st_ff.sel_at_halt)) begin
            // bus reads, captured one cycle ahead of the zero-wait access edge
            if (rd_setup) begin
                unique case (paddr)
                    OFS_DATA: nxt_st.rd = {24'h000000, st_ff.buf_rx};
                    OFS_CTL:  nxt_st.rd = {24'h000000, st_ff.ctl};
                    OFS_STS:  nxt_st.rd = {24'h000000, st_ff.sts};
                    OFS_PWR:  nxt_st.rd = {29'h0000000, st_ff.pwr};
                    OFS_WAKE: nxt_st.rd = {30'h0000000, wake_halt, irq};
                    default:  nxt_st.rd = 32'h00000000;
                endcase
            end
            // status access arms the done-flag clear; read clears overrun
            if (acc && paddr == OFS_STS) begin
                if (st_ff.sts[STS_TC]) nxt_st.tc_armed = 1'b1;
                if (!pwrite) begin
                    // only an overrun already shown in the read word is cleared
                    if (st_ff.rd[STS_OV]) nxt_st.sts[STS_OV] = 1'b0;
                    nxt_st.mf_armed = st_ff.sts[STS_MF];
                    nxt_st.sts[STS_WC] = 1'b0;
                end else begin
                    nxt_st.sts[2:0] = pwdata[2:0] & STS_WMASK[2:0];
                end
            end
            // control write; fault blocks enable and master until cleared
            if (wr_acc && paddr == OFS_CTL) begin
                nxt_st.ctl = pwdata[7:0];
                if (st_ff.sts[STS_MF] && !st_ff.mf_armed) begin
                    nxt_st.ctl[CTL_OE] = st_ff.ctl[CTL_OE];
                    nxt_st.ctl[CTL_MS] = st_ff.ctl[CTL_MS];
                end
                if (st_ff.mf_armed) begin
                    nxt_st.sts[STS_MF] = 1'b0;
                    nxt_st.mf_armed = 1'b0;
                end
                if (!pwdata[CTL_OE] || !pwdata[CTL_MS]) begin
                    nxt_st.busy = 1'b0;
                    nxt_st.sck  = pwdata[CTL_POL];
                end
            end
            // data access: clear done flag, load shifter when allowed
            if (acc && paddr == OFS_DATA) begin
                if (st_ff.tc_armed) begin
                    nxt_st.sts[STS_TC] = 1'b0;
                    nxt_st.tc_armed = 1'b0;
                end
                if (pwrite) begin
                    if (st_ff.busy) begin
                        nxt_st.sts[STS_WC] = 1'b1;
                    end else if (!st_ff.sts[STS_TC] || st_ff.tc_armed) begin
                        nxt_st.shf  = pwdata[7:0];
                        nxt_st.bitc = 4'h8;
                        nxt_st.busy = st_ff.ctl[CTL_MS] & st_ff.ctl[CTL_OE];
                        nxt_st.div  = half_div({st_ff.ctl[CTL_DIV], st_ff.ctl[1:0]});
                        nxt_st.edge2 = 1'b0;
                        nxt_st.sck  = st_ff.ctl[CTL_POL];
                    end
                end
            end
            // mode fault
            if (st_ff.ctl[CTL_MS] && !ss_in) begin
                nxt_st.sts[STS_MF] = 1'b1;
                nxt_st.ctl[CTL_OE] = 1'b0;
                nxt_st.ctl[CTL_MS] = 1'b0;
                nxt_st.busy = 1'b0;
                nxt_st.sck  = st_ff.ctl[CTL_POL];
            end else if (st_ff.ctl[CTL_MS] && st_ff.busy) begin
                // master sck generation
                if (st_ff.div == 7'h01) begin
                    nxt_st.div = half_div({st_ff.ctl[CTL_DIV], st_ff.ctl[1:0]});
                    nxt_st.sck = ~st_ff.sck;
                    master_select_edge = 1'b1;
                end else begin
                    nxt_st.div = st_ff.div - 7'h01;
                end
            end else if (!st_ff.ctl[CTL_MS] && st_ff.ctl[CTL_OE] && !ss_in &&
                         sck_in != sck_prev) begin
                slv_edge = 1'b1;
            end
            // edge classification: leading edge of a pair vs trailing
            if (master_select_edge || slv_edge) begin
                nxt_st.edge2 = ~st_ff.edge2;
                cap = (st_ff.edge2 == st_ff.ctl[CTL_PHA]);
                sft = ~cap;
            end
            if (cap) begin
                nxt_st.rxbit = din;
            end
            // phase 0 shifts on the other edge; phase 1 shifts the live bit in on the capture edge
            if (st_ff.ctl[CTL_PHA] ? cap : sft) begin
                shf_n = st_ff.ctl[CTL_PHA] ? {st_ff.shf[6:0], din}
                                           : {st_ff.shf[6:0], st_ff.rxbit};
                nxt_st.shf  = shf_n;
                nxt_st.bitc = st_ff.bitc - 4'h1;
                done = (st_ff.bitc == 4'h1);
            end
            if (done) begin
                // unread shifter keeps received byte, so it echoes back
                nxt_st.buf_rx = shf_n;
                nxt_st.busy   = 1'b0;
                nxt_st.bitc   = 4'h8;
                nxt_st.edge2  = 1'b0;
                if (st_ff.sts[STS_TC]) nxt_st.sts[STS_OV] = 1'b1;
                nxt_st.sts[STS_TC] = 1'b1;
            end
            if (!ss_in && st_ff.bitc == 4'h0) begin
                nxt_st.bitc = 4'h8;
            end
            // slave deselect aborts a partial byte
            if (!st_ff.ctl[CTL_MS] && ss_in) begin
                nxt_st.bitc  = 4'h8;
                nxt_st.edge2 = 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // sck chain resets to the idle low level so no false edge follows reset
            st_ff <= '{ctl: CTL_RST, sts: STS_RST, bitc: 4'h8,
                       ss_s: 3'h7, default: '0};
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // spimsp_port

/* File: design/spimsp_peer.sv */
// Purpose: partner end: simple master driving the port over the link
// Assumes: same pclk; user asks for one byte at a time
// Notes:   single slave so only one select is ever active
`timescale 1ns/1ps
module spimsp_peer
    import spimsp_pkg::*;
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // user side
    input  wire logic       start,
    input  wire logic [7:0] tx_byte,
    input  wire logic       pol,
    input  wire logic       pha,
    input  wire logic       hold_sel,
    output logic            busy,
    output logic            done,
    output logic [7:0]      rx_byte,
    // link
    spimsp_if.peer          lnk
);
    import spimsp_pkg::*;

    typedef struct packed {
        logic [7:0] shf;
        logic [7:0] rx;
        logic [4:0] edges;   // edges left in byte
        logic [3:0] cnt;     // half-period counter
        logic       sck;
        logic       sel;
        logic       run;
        logic       dn;
        logic [2:0] miso_s;  // pin synchroniser
    } spimsp_p_s;

    spimsp_p_s st_ff, nxt_st;

    assign busy  = st_ff.run;
    assign done  = st_ff.dn;
    assign rx_byte = st_ff.rx;
    assign lnk.ss_n      = ~(st_ff.sel | hold_sel);
    assign lnk.sck_o_p   = st_ff.sck;
    assign lnk.sck_oe_p  = 1'b1;
    assign lnk.mosi_o_p  = st_ff.shf[7];
    assign lnk.mosi_oe_p = 1'b1;
    assign lnk.miso_o_p  = 1'b0;
    assign lnk.miso_oe_p = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // byte engine, slow enough for the port's two-stage sampling
    always_comb begin
        logic lead;
        nxt_st = st_ff;
        nxt_st.dn = 1'b0;
        nxt_st.miso_s = {st_ff.miso_s[1:0], lnk.miso};
        lead = 1'b0;
        if (!st_ff.run) begin
            nxt_st.sck = pol;
            if (start) begin
                nxt_st.run = 1'b1;
                nxt_st.sel = 1'b1;
                nxt_st.shf = tx_byte;
                nxt_st.edges = 5'h10;
                nxt_st.cnt = 4'hF;
            end
        end else if (st_ff.cnt != 4'h0) begin
            nxt_st.cnt = st_ff.cnt - 4'h1;
        end else if (st_ff.edges == 5'h00) begin
            nxt_st.run = 1'b0;
            nxt_st.sel = 1'b0;
            nxt_st.dn  = 1'b1;
        end else begin
            nxt_st.cnt = 4'hF;
            nxt_st.sck = ~st_ff.sck;
            nxt_st.edges = st_ff.edges - 5'h01;
            lead = st_ff.edges[0] == 1'b0;
            if (lead == ~pha) begin
                nxt_st.rx = {st_ff.rx[6:0], st_ff.miso_s[1]};
            end else if (st_ff.edges != (pha ? 5'h10 : 5'h01)) begin
                // phase 1 already shows the first bit, so its first edge must not shift
                nxt_st.shf = {st_ff.shf[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
endmodule // spimsp_peer

/* File: dv/spimsp_chk_sva.sv */
// Purpose: wire-level checks on the link between the port and its partner end
// Assumes: one pclk domain, presetn asynchronous and active low
// Notes:   frame counters skip frames in which the port also drove the clock
`timescale 1ns/1ps
module spimsp_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // resolved wires
    input wire logic ss_n,
    input wire logic sck,
    // drive enables
    input wire logic sck_oe_d,
    input wire logic mosi_oe_d,
    input wire logic miso_oe_d,
    input wire logic miso_oe_p
);
    default clocking dcb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////
    logic       sck_q_ff;                    // clock level one cycle back
    logic [5:0] edges_ff;                    // transitions in this frame, bytes can chain
    logic [6:0] gap_ff;                      // cycles since last transition, saturating
    logic [6:0] last_ff;                     // gap seen at the previous transition
    logic       clean_ff;                    // partner alone clocked this frame
    logic       tgl;                         // transition this cycle
    assign tgl = sck != sck_q_ff;
    // frame bookkeeping, restarted whenever select is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q_ff <= 1'b0;
            edges_ff <= 6'h00;
            gap_ff   <= 7'h00;
            last_ff  <= 7'h00;
            clean_ff <= 1'b1;
        end else begin
            sck_q_ff <= sck;
            gap_ff   <= tgl ? 7'h01 : (gap_ff == 7'h7F ? gap_ff : gap_ff + 7'h01);
            if (ss_n) begin
                edges_ff <= 6'h00;
                clean_ff <= 1'b1;
            end else if (tgl) begin
                edges_ff <= edges_ff + 6'h01;
                last_ff  <= gap_ff;
            end
            // a fault frame has two clock owners, so counts mean nothing
            if (sck_oe_d) clean_ff <= 1'b0;
        end
    end
    ////////////////////////////////////////
    chk_reset_idle: assert property ($rose(presetn) |-> ss_n && !sck_oe_d && !miso_oe_d)
        else $error("link not idle after reset");
    chk_frame_bits: assert property ($rose(ss_n) && clean_ff |->
        edges_ff[3:0] == 4'h0 && edges_ff != 6'h00) else $error("frame not whole bytes");
    // the gap before a byte's first edge holds the pause between bytes, so skip two
    chk_even_duty: assert property (tgl && !ss_n && clean_ff && edges_ff[3:0] >= 4'd2 |->
        gap_ff == last_ff) else $error("clock half periods differ");
    chk_fault_drop: assert property (sck_oe_d && !ss_n |-> ##[1:6] !sck_oe_d)
        else $error("master kept clock while selected");
    chk_miso_release: assert property (ss_n [*4] |-> !miso_oe_d)
        else $error("port drives miso while deselected");
    chk_mosi_role: assert property (mosi_oe_d |-> sck_oe_d)
        else $error("port drives mosi as slave");
    chk_master_quiet: assert property (sck_oe_d |-> !miso_oe_d)
        else $error("master drives miso");
    chk_miso_single: assert property (!(miso_oe_d && miso_oe_p))
        else $error("miso driven by both ends");
endmodule // spimsp_chk

/* File: dv/spimsp_port_tb_top.sv */
// Purpose: self-checking bench joining the port and its partner end
// Assumes: pclk 125 MHz, registers at the package offsets
// Notes:   seeded xorshift stimulus plus fixed corner cases
`timescale 1ns/1ps
module spimsp_port_tb_top;
    import spimsp_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, wake_halt;
    logic [7:0]  paddr, tx_byte, rx_byte, t, d, q;
    logic [31:0] pwdata, prdata, seed, r, c;
    logic        start, pol, pha, hold_sel, busy, done, b;
    int          fails, samples_checked, n;
    logic        wake_seen;                      // halt wake request was raised
    logic [2:0]  codes [6] = '{3'b100, 3'b000, 3'b001, 3'b110, 3'b010, 3'b011};
    spimsp_if lnk();
    spimsp_port i_spimsp_port (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .lnk, .irq, .wake_halt);
    spimsp_peer i_spimsp_peer (.pclk, .presetn, .start, .tx_byte, .pol, .pha, .hold_sel,
        .busy, .done, .rx_byte, .lnk);
    spimsp_chk i_spimsp_chk (.pclk, .presetn, .ss_n(lnk.ss_n), .sck(lnk.sck),
        .sck_oe_d(lnk.sck_oe_d), .mosi_oe_d(lnk.mosi_oe_d), .miso_oe_d(lnk.miso_oe_d),
        .miso_oe_p(lnk.miso_oe_p));
    ////////////////////////////////////////
    // the wake request clears halt itself, so it stands one cycle: latch it here
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) wake_seen <= 1'b0;
        else if (wake_halt === 1'b1) wake_seen <= 1'b1;
    end
    // repeatable pseudo-random words
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // compare and count
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // one apb transfer; read data is taken at the edge where pready is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= v;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(r, e);
    endtask
    // one byte from the partner end, waiting for its done pulse
    task automatic xfer(input logic [7:0] v);
        int k;
        start   <= 1'b1;
        tx_byte <= v;
        @(posedge pclk);
        start <= 1'b0;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (done !== 1'b1 && k < 2000);
        if (k >= 2000) fails++;
    endtask
    task automatic results;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    ////////////////////////////////////////
    // free-running clock
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // watchdog sized well above the slowest divider sweep
    initial begin
        #(8 * 60000);
        fails++;
        results();
    end
    // main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {start, tx_byte, pol, pha, hold_sel} = '0;
        seed = 32'h20;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd_chk(OFS_CTL, {24'h0, CTL_RST});
        rd_chk(OFS_STS, {24'h0, STS_RST});
        rd_chk(8'h1C, 32'h0);
        // slave bytes over every mode, wait on, random mask and enable
        for (int i = 0; i < 12; i++) begin
            c = xs();
            apb(1'b1, OFS_PWR, {29'h0, c[4], 2'b01});
            apb(1'b1, OFS_CTL, 32'h0);
            pol <= c[0];
            pha <= c[1];
            apb(1'b1, OFS_CTL, {24'h0, c[6], 2'b10, 1'b0, c[0], c[1], c[3:2]});
            t = c[15:8];
            if (i % 3 == 2) d = q;
            else begin
                d = c[23:16];
                apb(1'b1, OFS_DATA, {24'h0, d});
            end
            xfer(t);
            chk(32'(rx_byte), {24'h0, d});
            rd_chk(OFS_STS, 32'h80);
            chk(32'(irq), {31'h0, c[6] & ~c[4]});
            rd_chk(OFS_DATA, {24'h0, t});
            rd_chk(OFS_STS, 32'h0);
            q = t;
        end
        // halt with select held low, two bytes before the flag is cleared
        apb(1'b1, OFS_CTL, 32'h0);
        pol <= 1'b0;
        pha <= 1'b1;
        apb(1'b1, OFS_CTL, 32'hC4);
        hold_sel <= 1'b1;
        repeat (4) @(posedge pclk);
        apb(1'b1, OFS_PWR, 32'h2);
        chk(32'(wake_seen), 32'h0);
        c = xs();
        t = c[7:0];
        xfer(t);
        chk(32'(wake_seen), 32'h1);
        rd_chk(OFS_PWR, 32'h0);
        xfer(~t);
        hold_sel <= 1'b0;
        rd_chk(OFS_STS, 32'hA0);
        rd_chk(OFS_DATA, {24'h0, ~t});
        xfer(8'h5A);
        rd_chk(OFS_STS, 32'h80);
        rd_chk(OFS_DATA, 32'h5A);
        apb(1'b1, OFS_PWR, 32'h0);
        // selected while master: fault drops enable and master bits
        apb(1'b1, OFS_CTL, 32'hD0);
        xfer(8'h3C);
        rd_chk(OFS_CTL, 32'h80);
        apb(1'b0, OFS_STS, 32'h0);
        chk(r & 32'h10, 32'h10);
        chk(32'(irq), 32'h1);
        apb(1'b1, OFS_CTL, 32'h0);
        apb(1'b0, OFS_DATA, 32'h0);
        // master clock rate for every divider code
        for (int k = 0; k < 6; k++) begin
            apb(1'b1, OFS_CTL, {24'h0, 2'b01, codes[k][2], 3'b100, codes[k][1:0]});
            c = xs();
            apb(1'b1, OFS_DATA, {24'h0, c[7:0]});
            b = lnk.sck;
            n = 0;
            while (lnk.sck === b && n < 300) begin
                @(posedge pclk);
                #1;
                n++;
            end
            b = lnk.sck;
            n = 0;
            while (lnk.sck === b && n < 300) begin
                @(posedge pclk);
                #1;
                n++;
            end
            chk(32'(n), 32'd2 << k);
            @(posedge pclk);
            n = 0;
            do begin
                apb(1'b0, OFS_STS, 32'h0);
                n++;
            end while (r[7] !== 1'b1 && n < 400);
            chk({31'h0, r[7]}, 32'h1);
            apb(1'b0, OFS_DATA, 32'h0);
        end
        results();
    end
endmodule // spimsp_port_tb_top
